// ---- rtl/bmf_pkg.sv ----
package bmf_pkg;

	// ----------------------------------------
	// Storage geometry
	// ----------------------------------------
	localparam int PTR_W = 13;
	localparam int BANK_AW = 11;
	localparam int OFS_W = 12;
	localparam logic [12:0] DEPTH_BYTES = 13'h1000;
	localparam logic [12:0] HALF_BYTES = 13'h0800;
	localparam logic [12:0] ONE_UNIT = 13'h0001;
	localparam logic [12:0] TWO_UNITS = 13'h0002;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	// Index of the last of the three read clock edges of the fall-through latency.
	localparam logic [1:0] FALL_LAST = 2'h2;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [11:0] A_CTRL = 12'h000;
	localparam logic [11:0] A_STAT = 12'h004;
	localparam logic [11:0] A_LEVEL = 12'h008;
	localparam logic [11:0] A_OFS = 12'h00C;
	localparam int CTRL_PRS_BIT = 0;

	// ----------------------------------------
	// Default offsets, indexed by {load, sel1, sel0}
	// ----------------------------------------
	localparam logic [7:0][11:0] DEF_OFS = {
		12'h3FF, 12'h1FF, 12'h0FF, 12'h07F,
		12'h03F, 12'h01F, 12'h00F, 12'h007
	};

	// ----------------------------------------
	// Pin bundle passed through the synchroniser
	// ----------------------------------------
	typedef struct packed {
		logic wclk;
		logic rclk;
		logic sclk;
		logic [17:0] d;
		logic wen_n;
		logic ren_n;
		logic mrs_n;
		logic prs_n;
		logic si;
		logic ld_n;
		logic sen_n;
		logic fs0;
		logic fs1;
		logic flag_timing_select;
		logic be;
		logic ip;
		logic iw;
		logic ow;
		logic mark;
		logic rt_n;
		logic rcs_n;
		logic oe_n;
	} bmf_pins_t;

endpackage

// ---- rtl/bmf_mem.sv ----
`timescale 1ns/10ps
`default_nettype none

// Two byte banks: bank 0 holds even byte addresses, bank 1 odd ones.
module bmf_mem (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	input wire logic [1:0] we_i,
	input wire logic [10:0] waddr_i,
	input wire logic [17:0] wdata_i,
	input wire logic [10:0] raddr_i,
	output logic [17:0] rdata_o
);

	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : bank
			logic [8:0] mem [0:2047];
			always_ff @(posedge clk_i)
			begin
				if (ce_i && we_i[g])
				begin
					mem[waddr_i] <= wdata_i[g*9 +: 9];
				end
			end
			// Read data comes from a register, so a write is visible one cycle later.
			always_ff @(posedge clk_i or negedge arst_n_i)
			begin
				if (!arst_n_i)
				begin
					rdata_o[g*9 +: 9] <= 9'h000;
				end
				else if (ce_i)
				begin
					rdata_o[g*9 +: 9] <= mem[raddr_i];
				end
			end
		end
	endgenerate

endmodule
`default_nettype wire

// ---- rtl/bmf_fifo.sv ----
// Summary of operation
// RULE1: fall-through shows first word after three read edges
// RULE2: reader strobes read for each later word
// RULE3: timing mode latched during master reset
// RULE4: fall-through output feeds next device directly
// RULE5: shared flags: empty/full or output/input ready
// RULE6: eight default offsets picked at master reset
// RULE7: serial bits shift in on serial clock
// RULE8: parallel offsets load from write data
// RULE9: strobed read with load shows offsets
// RULE10: master reset clears both pointers
// RULE11: partial reset clears pointers, keeps configuration
// RULE12: asynchronous almost-flags set and clear cross-clock
// RULE13: synchronous almost-flags follow own clock only
// RULE14: almost-flag timing latched at master reset
// RULE15: mark records current read location
// RULE16: retransmit returns read pointer to mark
// RULE17: width selects give four port width pairs
// RULE18: byte order sets which byte leaves first
// RULE19: parity position decides offset bits used
// RULE20: parity mode latched, used for wide writes
// RULE21: idle device powers down, wakes on control
// RULE22: output enable and chip select float outputs
// RULE23: port widths latched at master reset
// RULE24: strobed write edge stores write data
// RULE25: standard mode outputs only on strobed read
// RULE26: byte order select low big, high little
// RULE27: flags active low, high during master reset
//
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module bmf_fifo (
	input wire logic CLK_I,
	input wire logic ARST_N_I,
	input wire logic CE_I,
	input wire logic WRITE_CLK_I,
	input wire logic READ_CLK_I,
	input wire logic SERIAL_CLK_I,
	input wire logic [17:0] WRITE_DATA_IN_I,
	input wire logic WRITE_STROBE_N_I,
	input wire logic READ_STROBE_N_I,
	input wire logic MASTER_RESET_N_I,
	input wire logic PARTIAL_RESET_N_I,
	input wire logic FALL_THROUGH_MODE_SERIAL_IN_I,
	input wire logic OFFSET_LOAD_SELECT_N_I,
	input wire logic SERIAL_LOAD_ENABLE_N_I,
	input wire logic DEFAULT_OFFSET_SEL_0_I,
	input wire logic DEFAULT_OFFSET_SEL_1_I,
	input wire logic FLAG_TIMING_SELECT_I,
	input wire logic BYTE_ORDER_SELECT_I,
	input wire logic PARITY_POSITION_SELECT_I,
	input wire logic WRITE_WIDTH_SELECT_I,
	input wire logic READ_WIDTH_SELECT_I,
	input wire logic MARK_I,
	input wire logic RETRANSMIT_REQUEST_N_I,
	input wire logic READ_CHIP_SELECT_N_I,
	input wire logic OUTPUT_ENABLE_N_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [11:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	output logic [17:0] READ_DATA_OUT_O,
	output logic READ_DATA_OE_N_O,
	output logic EMPTY_FLAG_N_O,
	output logic FULL_FLAG_N_O,
	output logic HALF_FULL_FLAG_N_O,
	output logic ALMOST_EMPTY_FLAG_N_O,
	output logic ALMOST_FULL_FLAG_N_O,
	output logic POWER_DOWN_O
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		bmf_pkg::bmf_pins_t s1;
		bmf_pkg::bmf_pins_t s2;
		logic wclk_d;
		logic rclk_d;
		logic sclk_d;
		logic in_mrs;
		logic fall_through_mode;
		logic flag_timing_select;
		logic le;
		logic ip;
		logic w9;
		logic r9;
		logic [11:0] ae_ofs;
		logic [11:0] af_ofs;
		logic [12:0] wptr;
		logic [12:0] wptr_rd;
		logic [12:0] rptr;
		logic [12:0] mark;
		logic [1:0] wseq;
		logic [1:0] rseq;
		logic [1:0] fall_cnt;
		logic valid;
		logic rcs_n;
		logic [17:0] q;
		logic q_oe_n;
		logic ef_n;
		logic ff_n;
		logic hf_n;
		logic pae_n;
		logic paf_n;
		logic pd;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic soft_prs;
	} bmf_state_t;

	bmf_state_t st;
	bmf_state_t next_st;
	bmf_pkg::bmf_pins_t pins;
	logic wev;
	logic rev;
	logic sev;
	logic master_reset;
	logic partial_reset;
	logic recomp;
	logic rd_empty;
	logic wr_full;
	logic ef_c;
	logic full_c;
	logic ae_c;
	logic af_c;
	logic [12:0] run;
	logic [12:0] wun;
	logic [12:0] used;
	logic [12:0] free;
	logic [12:0] words_r;
	logic [12:0] words_w;
	logic [17:0] wword;
	logic [17:0] mem_w;
	logic [17:0] mem_r;
	logic [17:0] rword;
	logic [1:0] mem_we;
	logic [11:0] off;
	logic [11:0] pval;

	// Little-endian order swaps the two bytes of a wide word.
	function automatic logic [17:0] ord(input logic le, input logic [17:0] v);
		ord = le ? {v[8:0], v[17:9]} : v;
	endfunction

	assign pins = '{wclk: WRITE_CLK_I, rclk: READ_CLK_I, sclk: SERIAL_CLK_I,
		d: WRITE_DATA_IN_I, wen_n: WRITE_STROBE_N_I, ren_n: READ_STROBE_N_I,
		mrs_n: MASTER_RESET_N_I, prs_n: PARTIAL_RESET_N_I,
		si: FALL_THROUGH_MODE_SERIAL_IN_I, ld_n: OFFSET_LOAD_SELECT_N_I,
		sen_n: SERIAL_LOAD_ENABLE_N_I, fs0: DEFAULT_OFFSET_SEL_0_I,
		fs1: DEFAULT_OFFSET_SEL_1_I, flag_timing_select: FLAG_TIMING_SELECT_I,
		be: BYTE_ORDER_SELECT_I, ip: PARITY_POSITION_SELECT_I,
		iw: WRITE_WIDTH_SELECT_I, ow: READ_WIDTH_SELECT_I, mark: MARK_I,
		rt_n: RETRANSMIT_REQUEST_N_I, rcs_n: READ_CHIP_SELECT_N_I,
		oe_n: OUTPUT_ENABLE_N_I};

	bmf_mem u_mem (
		.clk_i(CLK_I),
		.arst_n_i(ARST_N_I),
		.ce_i(CE_I),
		.we_i(mem_we),
		.waddr_i(st.wptr[11:1]),
		.wdata_i(mem_w),
		.raddr_i(st.rptr[11:1]),
		.rdata_o(mem_r)
	);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		next_st = st;
		// Pins cross into this clock through two stages; only s2 is ever decoded.
		next_st.s1 = pins;
		next_st.s2 = st.s1;
		next_st.wclk_d = st.s2.wclk;
		next_st.rclk_d = st.s2.rclk;
		next_st.sclk_d = st.s2.sclk;
		wev = st.s2.wclk & ~st.wclk_d;
		rev = st.s2.rclk & ~st.rclk_d;
		sev = st.s2.sclk & ~st.sclk_d;
		master_reset = ~st.s2.mrs_n;
		partial_reset = ~st.s2.prs_n | st.soft_prs;
		recomp = partial_reset | (st.in_mrs & ~master_reset);
		next_st.in_mrs = master_reset;
		next_st.wptr_rd = st.wptr;
		run = st.r9 ? bmf_pkg::ONE_UNIT : bmf_pkg::TWO_UNITS;
		wun = st.w9 ? bmf_pkg::ONE_UNIT : bmf_pkg::TWO_UNITS;
		// Reads look at a write pointer one cycle old, so the memory has the data.
		rd_empty = (st.wptr_rd - st.rptr) < run;
		wr_full = (bmf_pkg::DEPTH_BYTES - (st.wptr - st.rptr)) < wun;
		rword = st.r9 ? {9'h000, st.rptr[0] ? mem_r[17:9] : mem_r[8:0]}
			: ord(st.le, {mem_r[8:0], mem_r[17:9]}); // see RULE17 RULE18
		wword = ord(st.le, st.s2.d); // see RULE18
		mem_we = 2'h0;
		mem_w = st.w9 ? {st.s2.d[8:0], st.s2.d[8:0]} : {wword[8:0], wword[17:9]};
		off = st.wseq[1] ? st.af_ofs : st.ae_ofs;
		if (st.w9)
		begin
			pval = st.wseq[0] ? {st.s2.d[3:0], off[7:0]} : {off[11:8], st.s2.d[7:0]};
		end
		else if (st.ip)
		begin
			pval = {st.s2.d[12:9], st.s2.d[7:0]}; // see RULE19 RULE20
		end
		else
		begin
			pval = st.s2.d[11:0]; // see RULE19
		end

		// Write side.
		if (wev && !st.s2.wen_n && !master_reset)
		begin
			if (!st.s2.ld_n)
			begin
				if (st.wseq[1])
				begin
					next_st.af_ofs = pval; // see RULE8
				end
				else
				begin
					next_st.ae_ofs = pval; // see RULE8
				end
				next_st.wseq = st.wseq + (st.w9 ? 2'h1 : 2'h2);
			end
			else if (!wr_full)
			begin
				mem_we = st.w9 ? (st.wptr[0] ? 2'h2 : 2'h1) : 2'h3; // see RULE24
				next_st.wptr = st.wptr + wun;
			end
		end

		// Serial offset loading shifts through both offsets, almost-empty first.
		if (sev && !st.s2.sen_n && !st.s2.ld_n && !master_reset)
		begin
			{next_st.af_ofs, next_st.ae_ofs} = {st.af_ofs[10:0], st.ae_ofs, st.s2.si}; // see RULE7
		end

		// Read side.
		if (rev && !master_reset)
		begin
			next_st.rcs_n = st.s2.rcs_n; // see RULE22
			if (st.s2.mark)
			begin
				next_st.mark = st.rptr; // see RULE15
			end
			if (!st.s2.rt_n)
			begin
				next_st.rptr = st.mark; // see RULE16
				next_st.valid = 1'b0;
				next_st.fall_cnt = 2'h0;
			end
			else if (!st.s2.ren_n && !st.s2.ld_n)
			begin
				off = st.rseq[1] ? st.af_ofs : st.ae_ofs;
				next_st.q = st.r9 ? {9'h000, st.rseq[0] ? {5'h00, off[11:8]} : {1'h0, off[7:0]}}
					: {6'h00, off}; // see RULE9
				next_st.rseq = st.rseq + (st.r9 ? 2'h1 : 2'h2);
			end
			else if (!st.fall_through_mode)
			begin
				if (!st.s2.ren_n && !rd_empty)
				begin
					next_st.q = rword; // see RULE25
					next_st.rptr = st.rptr + run;
				end
			end
			else if (st.valid && !st.s2.ren_n)
			begin
				// A taken word is replaced at once when another is waiting.
				if (!rd_empty)
				begin
					next_st.q = rword; // see RULE2 RULE4
					next_st.rptr = st.rptr + run;
				end
				else
				begin
					next_st.valid = 1'b0;
				end
			end
			else if (!st.valid)
			begin
				if (rd_empty)
				begin
					next_st.fall_cnt = 2'h0;
				end
				else if (st.fall_cnt == bmf_pkg::FALL_LAST)
				begin
					next_st.q = rword; // see RULE1
					next_st.rptr = st.rptr + run;
					next_st.valid = 1'b1;
					next_st.fall_cnt = 2'h0;
				end
				else
				begin
					next_st.fall_cnt = st.fall_cnt + 2'h1; // see RULE1
				end
			end
		end

		// Resets.
		if (master_reset)
		begin
			next_st.fall_through_mode = st.s2.si; // see RULE3
			next_st.flag_timing_select = st.s2.flag_timing_select; // see RULE14
			next_st.le = st.s2.be; // see RULE26
			next_st.ip = st.s2.ip & ~st.s2.iw; // see RULE20
			next_st.w9 = st.s2.iw; // see RULE23 RULE17
			next_st.r9 = st.s2.ow; // see RULE23 RULE17
			next_st.ae_ofs = bmf_pkg::DEF_OFS[{st.s2.ld_n, st.s2.fs1, st.s2.fs0}]; // see RULE6
			next_st.af_ofs = bmf_pkg::DEF_OFS[{st.s2.ld_n, st.s2.fs1, st.s2.fs0}]; // see RULE6
			next_st.q = 18'h00000;
		end
		if (master_reset || partial_reset)
		begin
			next_st.wptr = 13'h0000; // see RULE10 RULE11
			next_st.wptr_rd = 13'h0000;
			next_st.rptr = 13'h0000; // see RULE10 RULE11
			next_st.mark = 13'h0000;
			next_st.wseq = 2'h0;
			next_st.rseq = 2'h0;
			next_st.fall_cnt = 2'h0;
			next_st.valid = 1'b0;
		end

		// Flags from the pointers after this cycle.
		run = next_st.r9 ? bmf_pkg::ONE_UNIT : bmf_pkg::TWO_UNITS;
		wun = next_st.w9 ? bmf_pkg::ONE_UNIT : bmf_pkg::TWO_UNITS;
		used = next_st.wptr - next_st.rptr;
		free = bmf_pkg::DEPTH_BYTES - used;
		ef_c = used < run;
		full_c = free < wun;
		words_r = next_st.r9 ? used : {1'b0, used[12:1]};
		words_w = next_st.w9 ? free : {1'b0, free[12:1]};
		ae_c = words_r <= {1'b0, next_st.ae_ofs};
		af_c = words_w <= {1'b0, next_st.af_ofs};
		next_st.ef_n = next_st.fall_through_mode ? ~next_st.valid : ~ef_c; // see RULE5
		next_st.ff_n = next_st.fall_through_mode ? full_c : ~full_c; // see RULE5 RULE27
		next_st.hf_n = ~(used > bmf_pkg::HALF_BYTES); // see RULE5
		if (recomp)
		begin
			next_st.pae_n = ~ae_c; // see RULE11
			next_st.paf_n = ~af_c; // see RULE11
		end
		else if (next_st.flag_timing_select)
		begin
			if (rev)
			begin
				next_st.pae_n = ~ae_c; // see RULE13
			end
			if (wev)
			begin
				next_st.paf_n = ~af_c; // see RULE13
			end
		end
		else
		begin
			if (rev && ae_c)
			begin
				next_st.pae_n = 1'b0; // see RULE12
			end
			else if (wev && !ae_c)
			begin
				next_st.pae_n = 1'b1; // see RULE12
			end
			if (wev && af_c)
			begin
				next_st.paf_n = 1'b0; // see RULE12
			end
			else if (rev && !af_c)
			begin
				next_st.paf_n = 1'b1; // see RULE12
			end
		end
		if (master_reset)
		begin
			next_st.ef_n = 1'b1; // see RULE27
			next_st.ff_n = 1'b1;
			next_st.hf_n = 1'b1;
			next_st.pae_n = 1'b1;
			next_st.paf_n = 1'b1;
		end
		next_st.q_oe_n = st.s2.oe_n | next_st.rcs_n; // see RULE22
		// Any asserted strobe or reset counts as activity.
		next_st.pd = st.s2.wen_n & st.s2.ren_n & st.s2.sen_n & ~master_reset & ~partial_reset; // see RULE21

		// Register bus: zero-wait slave, answer ready in the access phase.
		next_st.pready = 1'b0;
		next_st.soft_prs = 1'b0;
		if (PSEL_I && !PENABLE_I)
		begin
			next_st.pready = 1'b1;
			next_st.pslverr = 1'b0;
			next_st.prdata = 32'h00000000;
			if (PADDR_I == bmf_pkg::A_CTRL)
			begin
				next_st.prdata = 32'h00000000;
			end
			else if (PADDR_I == bmf_pkg::A_STAT)
			begin
				next_st.prdata = {18'h00000, st.r9, st.w9, st.ip, st.le, st.flag_timing_select, st.fall_through_mode,
					1'b0, st.valid, st.pd, st.paf_n, st.pae_n, st.hf_n, st.ff_n, st.ef_n};
			end
			else if (PADDR_I == bmf_pkg::A_LEVEL)
			begin
				next_st.prdata = {19'h00000, st.wptr - st.rptr};
			end
			else if (PADDR_I == bmf_pkg::A_OFS)
			begin
				next_st.prdata = {4'h0, st.af_ofs, 4'h0, st.ae_ofs};
			end
			else
			begin
				next_st.pslverr = 1'b1;
			end
		end
		else if (PSEL_I && PENABLE_I && st.pready)
		begin
			if (PWRITE_I && PADDR_I == bmf_pkg::A_CTRL)
			begin
				next_st.soft_prs = PWDATA_I[bmf_pkg::CTRL_PRS_BIT];
			end
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge CLK_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
		begin
			st <= '0;
			st.ef_n <= 1'b1;
			st.ff_n <= 1'b1;
			st.hf_n <= 1'b1;
			st.pae_n <= 1'b1;
			st.paf_n <= 1'b1;
			st.rcs_n <= 1'b1;
			st.q_oe_n <= 1'b1;
			st.pd <= 1'b1;
		end
		else if (CE_I)
		begin
			st <= next_st;
		end
	end

	assign PRDATA_O = st.prdata;
	assign PREADY_O = st.pready;
	assign PSLVERR_O = st.pslverr;
	assign READ_DATA_OUT_O = st.q;
	assign READ_DATA_OE_N_O = st.q_oe_n;
	assign EMPTY_FLAG_N_O = st.ef_n;
	assign FULL_FLAG_N_O = st.ff_n;
	assign HALF_FULL_FLAG_N_O = st.hf_n;
	assign ALMOST_EMPTY_FLAG_N_O = st.pae_n;
	assign ALMOST_FULL_FLAG_N_O = st.paf_n;
	assign POWER_DOWN_O = st.pd;

endmodule
`default_nettype wire

// ---- verif/bmf_fifo_chk.sv ----
`timescale 1ns/10ps
`default_nettype none

module bmf_fifo_chk (
	input wire logic CLK_I,
	input wire logic ARST_N_I,
	input wire logic CE_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic [11:0] PADDR_I,
	input wire logic MASTER_RESET_N_I,
	input wire logic FALL_THROUGH_MODE_SERIAL_IN_I,
	input wire logic WRITE_STROBE_N_I,
	input wire logic READ_CLK_I,
	input wire logic OUTPUT_ENABLE_N_I,
	input wire logic [31:0] PRDATA_O,
	input wire logic PREADY_O,
	input wire logic PSLVERR_O,
	input wire logic [17:0] READ_DATA_OUT_O,
	input wire logic READ_DATA_OE_N_O,
	input wire logic EMPTY_FLAG_N_O,
	input wire logic FULL_FLAG_N_O,
	input wire logic HALF_FULL_FLAG_N_O,
	input wire logic ALMOST_EMPTY_FLAG_N_O,
	input wire logic ALMOST_FULL_FLAG_N_O,
	input wire logic POWER_DOWN_O
);
	// Pins pass a two-flop synchroniser, hence the windows of five cycles.
	default clocking @(posedge CLK_I);
	endclocking
	default disable iff (!ARST_N_I || !CE_I);

	logic std_mode;

	// Mode as picked at master reset; only trusted once that reset is over.
	always_ff @(posedge CLK_I)
	begin
		if (!MASTER_RESET_N_I)
		begin
			std_mode <= !FALL_THROUGH_MODE_SERIAL_IN_I;
		end
	end

	a_flags_in_reset:
	assert property (!MASTER_RESET_N_I [*5] |-> EMPTY_FLAG_N_O && FULL_FLAG_N_O
		&& HALF_FULL_FLAG_N_O && ALMOST_EMPTY_FLAG_N_O && ALMOST_FULL_FLAG_N_O)
		else $error("flags low during master reset");
	a_full_implies_rest:
	assert property (std_mode && MASTER_RESET_N_I && !FULL_FLAG_N_O |->
		!ALMOST_FULL_FLAG_N_O && !HALF_FULL_FLAG_N_O)
		else $error("full without half and almost full");
	a_pready_one_cycle:
	assert property (PSEL_I && !PENABLE_I |=> PREADY_O ##1 !PREADY_O)
		else $error("ready not a single pulse after setup");
	a_unmapped_error:
	assert property (PSEL_I && !PENABLE_I && PADDR_I > 12'h00C |=> PSLVERR_O && PRDATA_O == 32'h0)
		else $error("unmapped access not flagged");
	a_rdata_holds:
	assert property (!(PSEL_I && !PENABLE_I) |=> $stable(PRDATA_O))
		else $error("read data moved without setup");
	a_output_float:
	assert property (OUTPUT_ENABLE_N_I [*5] |-> READ_DATA_OE_N_O)
		else $error("outputs driven while disabled");
	a_busy_no_sleep:
	assert property (!WRITE_STROBE_N_I [*5] |-> !POWER_DOWN_O)
		else $error("powered down during write strobe");
	a_data_quiet:
	assert property ((!READ_CLK_I && MASTER_RESET_N_I && !PSEL_I) [*8] |-> $stable(READ_DATA_OUT_O))
		else $error("read data changed without read clock");
endmodule

bind bmf_fifo bmf_fifo_chk chk (.*);

`default_nettype wire

// ---- verif/bmf_partner.sv ----
`timescale 1ns/10ps
`default_nettype none

module bmf_partner (
	input wire logic clk_i,
	output logic wclk_o,
	output logic rclk_o,
	output logic [17:0] wdata_o,
	output logic wen_n_o,
	output logic ren_n_o
);
	initial
	begin
		wclk_o = 1'b0;
		rclk_o = 1'b0;
		wdata_o = 18'h00000;
		wen_n_o = 1'b1;
		ren_n_o = 1'b1;
	end

	// Pin clocks stay three cycles in each level; shorter pulses slip past the synchroniser.
	task automatic beat(input logic rd);
		repeat (3) @(posedge clk_i);
		if (rd)
			rclk_o <= 1'b1;
		else
			wclk_o <= 1'b1;
		repeat (3) @(posedge clk_i);
		rclk_o <= 1'b0;
		wclk_o <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask

	// The bus is inverted once released, so stale data can never look valid.
	task automatic wr(input logic [17:0] d, input logic en_n);
		@(posedge clk_i);
		wen_n_o <= en_n;
		wdata_o <= d;
		beat(1'b0);
		wen_n_o <= 1'b1;
		wdata_o <= ~d;
	endtask

	task automatic rd(input logic en_n);
		@(posedge clk_i);
		ren_n_o <= en_n;
		beat(1'b1);
		ren_n_o <= 1'b1;
	endtask
endmodule

`default_nettype wire

// ---- verif/bmf_fifo_tb.sv ----
`timescale 1ns/10ps
`default_nettype none

module bmf_fifo_tb;
	logic CLK_I = 1'b0, ARST_N_I = 1'b0, CE_I = 1'b1, SERIAL_CLK_I = 1'b0;
	logic SERIAL_LOAD_ENABLE_N_I = 1'b1, PARTIAL_RESET_N_I = 1'b1, READ_CHIP_SELECT_N_I = 1'b0;
	logic MASTER_RESET_N_I = 1'b0, MARK_I = 1'b0, RETRANSMIT_REQUEST_N_I = 1'b1;
	logic OUTPUT_ENABLE_N_I = 1'b0, FALL_THROUGH_MODE_SERIAL_IN_I = 1'b0;
	logic READ_WIDTH_SELECT_I = 1'b0, WRITE_WIDTH_SELECT_I = 1'b0, PARITY_POSITION_SELECT_I = 1'b0;
	logic BYTE_ORDER_SELECT_I = 1'b0, FLAG_TIMING_SELECT_I = 1'b0, OFFSET_LOAD_SELECT_N_I = 1'b1;
	logic DEFAULT_OFFSET_SEL_1_I = 1'b0, DEFAULT_OFFSET_SEL_0_I = 1'b0;
	logic PSEL_I = 1'b0, PENABLE_I = 1'b0, PWRITE_I = 1'b0;
	logic [11:0] PADDR_I = 12'h000;
	logic [31:0] PWDATA_I = 32'h00000000;
	logic WRITE_CLK_I, READ_CLK_I, WRITE_STROBE_N_I, READ_STROBE_N_I;
	logic [17:0] WRITE_DATA_IN_I, READ_DATA_OUT_O;
	logic [31:0] PRDATA_O;
	logic PREADY_O, PSLVERR_O, READ_DATA_OE_N_O, EMPTY_FLAG_N_O, FULL_FLAG_N_O;
	logic HALF_FULL_FLAG_N_O, ALMOST_EMPTY_FLAG_N_O, ALMOST_FULL_FLAG_N_O, POWER_DOWN_O;
	int fails = 0;
	int checks_done = 0;

	bmf_fifo DUT (.*);
	bmf_partner bfm (
		.clk_i(CLK_I),
		.wclk_o(WRITE_CLK_I),
		.rclk_o(READ_CLK_I),
		.wdata_o(WRITE_DATA_IN_I),
		.wen_n_o(WRITE_STROBE_N_I),
		.ren_n_o(READ_STROBE_N_I)
	);

	initial
		forever #10 CLK_I = ~CLK_I;

	// ----------------------------------------
	// Access tasks
	// ----------------------------------------
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e)
		begin
			fails++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge CLK_I);
		PSEL_I <= 1'b1;
		PWRITE_I <= w;
		PADDR_I <= a;
		PWDATA_I <= d;
		@(posedge CLK_I);
		PENABLE_I <= 1'b1;
		do
			@(posedge CLK_I);
		while (PREADY_O !== 1'b1);
		q = PRDATA_O;
		PSEL_I <= 1'b0;
		PENABLE_I <= 1'b0;
	endtask

	// Configuration pins stay put a while after release, past the synchroniser.
	task automatic master_reset(input logic [8:0] c);
		@(posedge CLK_I);
		{FALL_THROUGH_MODE_SERIAL_IN_I, READ_WIDTH_SELECT_I, WRITE_WIDTH_SELECT_I,
			PARITY_POSITION_SELECT_I, BYTE_ORDER_SELECT_I, FLAG_TIMING_SELECT_I,
			OFFSET_LOAD_SELECT_N_I, DEFAULT_OFFSET_SEL_1_I, DEFAULT_OFFSET_SEL_0_I} <= c;
		MASTER_RESET_N_I <= 1'b0;
		repeat (6) @(posedge CLK_I);
		MASTER_RESET_N_I <= 1'b1;
		repeat (4) @(posedge CLK_I);
		OFFSET_LOAD_SELECT_N_I <= 1'b1;
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial
	begin
		logic [31:0] q;
		repeat (20) @(posedge CLK_I);
		ARST_N_I <= 1'b1;
		for (int i = 0; i < 8; i++)
		begin
			master_reset({1'b0, i[1], 1'b0, i[2], i[0], i[1], i[2], i[1], i[0]});
			apb(1'b0, bmf_pkg::A_OFS, 32'h0, q);
			chk("defaults", q, {4'h0, bmf_pkg::DEF_OFS[i], 4'h0, bmf_pkg::DEF_OFS[i]});
			apb(1'b0, bmf_pkg::A_STAT, 32'h0, q);
			chk("config", {q[13:8], q[4:0]}, {i[1], 1'b0, i[2], i[0], i[1], 6'h16});
		end
		master_reset(9'h000);
		for (int i = 0; i < 2049; i++)
			bfm.wr(18'(i + 256), 1'b0);
		chk("full", {FULL_FLAG_N_O, HALF_FULL_FLAG_N_O, ALMOST_FULL_FLAG_N_O, EMPTY_FLAG_N_O}, 4'h1);
		chk("no_read", READ_DATA_OUT_O, 18'h00000);
		MARK_I <= 1'b1;
		bfm.rd(1'b0);
		MARK_I <= 1'b0;
		chk("first", {FULL_FLAG_N_O, READ_DATA_OUT_O}, 19'h40100);
		bfm.rd(1'b0);
		chk("second", READ_DATA_OUT_O, 18'h00101);
		RETRANSMIT_REQUEST_N_I <= 1'b0;
		bfm.rd(1'b1);
		RETRANSMIT_REQUEST_N_I <= 1'b1;
		bfm.rd(1'b0);
		chk("again", READ_DATA_OUT_O, 18'h00100);
		apb(1'b1, bmf_pkg::A_CTRL, 32'h1, q);
		repeat (4) @(posedge CLK_I);
		apb(1'b0, bmf_pkg::A_STAT, 32'h0, q);
		chk("partial", {q[13:8], q[4:0]}, 32'h16);
		apb(1'b0, bmf_pkg::A_OFS, 32'h0, q);
		chk("kept", q, 32'h00070007);
		apb(1'b0, 12'h010, 32'h0, q);
		chk("unmapped", {PSLVERR_O, q[30:0]}, 32'h80000000);
		OFFSET_LOAD_SELECT_N_I <= 1'b0;
		bfm.wr(18'h30123, 1'b0);
		bfm.wr(18'h30456, 1'b0);
		bfm.rd(1'b0);
		OFFSET_LOAD_SELECT_N_I <= 1'b1;
		chk("readback", READ_DATA_OUT_O[11:0], 12'h123);
		apb(1'b0, bmf_pkg::A_OFS, 32'h0, q);
		chk("loaded", q, 32'h04560123);
		q = 32'h005A30A5;
		OFFSET_LOAD_SELECT_N_I <= 1'b0;
		SERIAL_LOAD_ENABLE_N_I <= 1'b0;
		for (int b = 23; b >= 0; b--)
		begin
			FALL_THROUGH_MODE_SERIAL_IN_I <= q[b];
			repeat (3) @(posedge CLK_I);
			SERIAL_CLK_I <= 1'b1;
			repeat (3) @(posedge CLK_I);
			SERIAL_CLK_I <= 1'b0;
		end
		SERIAL_LOAD_ENABLE_N_I <= 1'b1;
		OFFSET_LOAD_SELECT_N_I <= 1'b1;
		apb(1'b0, bmf_pkg::A_OFS, 32'h0, q);
		chk("serial", q, 32'h05A300A5);
		master_reset(9'h194);
		bfm.wr({9'h1C3, 9'h03C}, 1'b0);
		repeat (3) bfm.rd(1'b1);
		chk("fall", {EMPTY_FLAG_N_O, FULL_FLAG_N_O, READ_DATA_OUT_O[8:0]}, 11'h03C);
		bfm.rd(1'b0);
		chk("byte2", READ_DATA_OUT_O[8:0], 9'h1C3);
		bfm.wr(18'h00055, 1'b0);
		apb(1'b0, bmf_pkg::A_LEVEL, 32'h0, q);
		chk("level", q, 32'h2);
		PARTIAL_RESET_N_I <= 1'b0;
		repeat (4) @(posedge CLK_I);
		PARTIAL_RESET_N_I <= 1'b1;
		apb(1'b0, bmf_pkg::A_LEVEL, 32'h0, q);
		chk("level_prs", q, 32'h0);
		READ_CHIP_SELECT_N_I <= 1'b1;
		bfm.rd(1'b1);
		chk("rcs_float", READ_DATA_OE_N_O, 1'b1);
		READ_CHIP_SELECT_N_I <= 1'b0;
		bfm.rd(1'b1);
		chk("rcs_drive", READ_DATA_OE_N_O, 1'b0);
		CE_I <= 1'b0;
		OUTPUT_ENABLE_N_I <= 1'b1;
		repeat (5) @(posedge CLK_I);
		chk("frozen", READ_DATA_OE_N_O, 1'b0);
		CE_I <= 1'b1;
		repeat (5) @(posedge CLK_I);
		chk("float", {READ_DATA_OE_N_O, POWER_DOWN_O}, 2'h3);
		OUTPUT_ENABLE_N_I <= 1'b0;
		repeat (5) @(posedge CLK_I);
		chk("drive", READ_DATA_OE_N_O, 1'b0);
		give_verdict();
	end

	// The fill of the store dominates; about 21k cycles are expected.
	initial
	begin
		repeat (80000) @(posedge CLK_I);
		fails++;
		give_verdict();
	end
endmodule

`default_nettype wire
